// ===== csh_defines.vh
// constants for the component sorter handshake block
`ifndef CSH_DEFINES_VH
`define CSH_DEFINES_VH
// clock rate in kHz
`define CSH_CLK_KHZ        10000
// least trigger pulse width in ns
`define CSH_TRIG_MIN_NS    1000
// trigger width in cycles, rounded up
`define CSH_TRIG_CYCLES    ((`CSH_TRIG_MIN_NS * `CSH_CLK_KHZ + 999999) / 1000000)
// width count at which the start fires, the acting sample is the last one
`define CSH_TRIG_ARM_LAST  (`CSH_TRIG_CYCLES - 1)
// comparison modes
`define CSH_MODE_BIN       1'b0
`define CSH_MODE_LIST      1'b1
// number of bin select lines
`define CSH_NUM_BINS       9
// class codes reported by the measurement core
`define CSH_CLASS_GOOD     2'h0
`define CSH_CLASS_OVER     2'h1
`define CSH_CLASS_NG       2'h2
// reset value of all active-low outputs
`define CSH_OUT_IDLE       1'b1
`endif

// ===== csh_handler_port.v
// handler port output and handshake logic of the component sorter
// ****************************************
// Function
// - all sorting and control outputs active low
// - external trigger mode starts on rising edge
// - panel lock masks front panel keys
// - fault alert on measurement circuit break
// - analog done when analog test finishes
// - results valid by end of measurement
// - end of measurement after data valid; here both change on the same clock edge
// - bin mode classifies good, over, not good
// - primary high above bins 1-9 upper limit
// - primary low below bins 1-9 lower limit
// - secondary reject outside secondary limits
// - list mode: per point flags, aux fail
// - list mode updates outputs after sweep, or after each point in per point sweep
// - sequential sweep: analog done after last
// - per point sweep: analog done each point
// - sequential sweep: end after all tasks
// - per point sweep: end after each step
// ****************************************
`timescale 1ns/10ps
`default_nettype none
`include "csh_defines.vh"

module csh_handler_port (
    input  wire        clock_i,
    input  wire        nrst_i,
    input  wire        ext_trigger_in_mode_i,
    input  wire        ext_trigger_in_i,
    input  wire        panel_lock_n_i,
    input  wire [15:0] panel_keys_i,
    output wire [15:0] panel_keys_o,
    input  wire        circuit_break_i,
    input  wire        compare_mode_i,
    input  wire        sequential_sweep_i,
    input  wire [3:0]  sweep_points_i,
    input  wire        analog_step_i,
    input  wire        compare_step_i,
    input  wire [3:0]  point_index_i,
    input  wire        point_fail_i,
    input  wire [1:0]  bin_class_i,
    input  wire [3:0]  bin_number_i,
    input  wire        aux_bin_i,
    input  wire        prim_above_i,
    input  wire        prim_below_i,
    input  wire        sec_outside_i,
    output wire        meas_start_o,
    output reg  [8:0]  bin_select_n_o,
    output reg         out_of_bin_n_o,
    output reg         aux_n_o,
    output reg         primary_high_n_o,
    output reg         primary_low_n_o,
    output reg         secondary_reject_n_o,
    output reg         analog_done_n_o,
    output reg         measure_done_n_o,
    output reg         fault_alert_n_o
);

    // ****************************************
    // reset and input synchronisers
    // ****************************************
    reg        rst_s1_q;
    reg        rst_s2_q;
    wire       rst_n;
    reg  [2:0] trig_s1_q;
    reg  [2:0] trig_s2_q;
    wire       trig_s;
    wire       lock_s;
    wire       brk_s;
    reg        trig_prev_q;
    reg  [3:0] trig_wid_q;
    reg        trig_armed_q;
    reg [15:0] keys_q;

    // reset release through two flops
    // the rising edge of the pin is retimed so that every flop below leaves
    // reset on the same clock edge; assertion still acts at once
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // pin inputs pass two flops
    // reset values are the idle pin levels: trigger low, lock released,
    // no break, so the edge detector sees no false edge after reset
    // and the key mask does not act until the pin really asks for it
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            trig_s1_q <= 3'h2;
            trig_s2_q <= 3'h2;
        end else begin
            trig_s1_q <= {circuit_break_i, panel_lock_n_i, ext_trigger_in_i};
            trig_s2_q <= trig_s1_q;
        end
    end
    assign trig_s = trig_s2_q[0];
    assign lock_s = ~trig_s2_q[1];
    assign brk_s  = trig_s2_q[2];

    // keys are dropped while the lock pin is low; the mask is registered
    // so the key word leaves the block from flops like every data output
    // the mask lags the pin by three edges
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            keys_q <= 16'h0000;
        end else if (lock_s) begin
            keys_q <= 16'h0000;
        end else begin
            keys_q <= panel_keys_i;
        end
    end
    assign panel_keys_o = keys_q;

    // ****************************************
    // external trigger edge detection
    // ****************************************
    // a rising edge arms; start fires once the high level has lasted the least width
    // the count includes the sample taken on the edge that acts on the start,
    // so a pulse of exactly the least width is taken and one cycle less is not
    // a pulse that drops early disarms and has to rise again to count
    // only one start comes from one pulse, however long it stays high
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            trig_prev_q  <= 1'b0;
            trig_wid_q   <= 4'h0;
            trig_armed_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_s;
            if (trig_s && !trig_prev_q) begin
                trig_armed_q <= 1'b1;
                trig_wid_q   <= 4'h1;
            end else if (!trig_s) begin
                trig_armed_q <= 1'b0; // too short a pulse is dropped
                trig_wid_q   <= 4'h0;
            end else if (trig_armed_q) begin
                if (trig_wid_q >= `CSH_TRIG_ARM_LAST) begin
                    trig_armed_q <= 1'b0;
                end
                trig_wid_q <= trig_wid_q + 4'h1;
            end
        end
    end

    // start pulse, only in external trigger mode
    // the mode bit comes from logic on this clock, so it is not retimed;
    // a pulse seen while the mode is off is counted but never starts
    assign meas_start_o = ext_trigger_in_mode_i & trig_armed_q & trig_s
                          & (trig_wid_q >= `CSH_TRIG_ARM_LAST);

    // ****************************************
    // sweep sequencing
    // ****************************************
    reg  [3:0] analog_cnt_q;
    reg  [3:0] comp_cnt_q;
    reg  [9:0] fail_map_q;
    wire       list_mode;
    wire       last_analog;
    wire       last_comp;
    wire [9:0] fail_next;
    genvar     gi;

    // the last step is found by the running count against the point count;
    // a point count of zero is treated like one, the first step is the last
    // a step beyond the count marks the end again
    assign list_mode   = (compare_mode_i == `CSH_MODE_LIST);
    assign last_analog = analog_step_i & (analog_cnt_q + 4'h1 >= sweep_points_i);
    assign last_comp   = compare_step_i & (comp_cnt_q + 4'h1 >= sweep_points_i);

    // per-point fail flags collected during the sweep
    // point nine has no bin line of its own and lands on the out-of-bin flag;
    // an index above nine matches no flag and is lost
    generate
        for (gi = 0; gi < 10; gi = gi + 1) begin : g_fail
            assign fail_next[gi] = fail_map_q[gi]
                                   | (compare_step_i & point_fail_i
                                      & (point_index_i == gi));
        end
    endgenerate

    // counters for analog and compare steps within one measurement
    // a start clears the counts and the fail flags; a step that lands in the
    // start cycle itself is dropped, since it belongs to the measurement
    // that is being ended
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            analog_cnt_q <= 4'h0;
            comp_cnt_q   <= 4'h0;
            fail_map_q   <= 10'h000;
        end else if (meas_start_o) begin
            analog_cnt_q <= 4'h0;
            comp_cnt_q   <= 4'h0;
            fail_map_q   <= 10'h000;
        end else begin
            if (analog_step_i) begin
                analog_cnt_q <= analog_cnt_q + 4'h1;
            end
            if (compare_step_i) begin
                comp_cnt_q <= comp_cnt_q + 4'h1;
            end
            fail_map_q <= fail_next;
        end
    end

    // ****************************************
    // control outputs
    // ****************************************
    reg analog_event;
    reg done_event;

    // choose the event that marks analog done and end of measurement
    // bin mode and per-point sweep mark every step; the sequential sweep
    // waits for the last point, so the handler sees one analog done and
    // one end of measurement per part
    always @* begin
        if (!list_mode) begin
            analog_event = analog_step_i;
            done_event   = compare_step_i;
        end else if (sequential_sweep_i) begin
            analog_event = last_analog;
            done_event   = last_comp;
        end else begin
            analog_event = analog_step_i;
            done_event   = compare_step_i;
        end
    end

    // done outputs go high at start and low on their events
    // both lines are levels: once low they stay low until the next start,
    // which with reset is the only thing that raises them again
    // the alarm line simply follows the retimed break pin
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            analog_done_n_o  <= `CSH_OUT_IDLE;
            measure_done_n_o <= `CSH_OUT_IDLE;
            fault_alert_n_o  <= `CSH_OUT_IDLE;
        end else begin
            fault_alert_n_o <= ~brk_s;
            if (meas_start_o) begin
                analog_done_n_o  <= 1'b1;
                measure_done_n_o <= 1'b1;
            end else begin
                if (analog_event) begin
                    analog_done_n_o <= 1'b0;
                end
                if (done_event) begin
                    measure_done_n_o <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // comparison result outputs
    // ****************************************
    // results load in the same edge as end of measurement and hold after it
    // a start does not clear the results: the handler may still be reading
    // them, and the next end of measurement overwrites them anyway
    // in list mode the main and secondary limit lines are not used and
    // stay released
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            bin_select_n_o       <= {`CSH_NUM_BINS{`CSH_OUT_IDLE}};
            out_of_bin_n_o       <= `CSH_OUT_IDLE;
            aux_n_o              <= `CSH_OUT_IDLE;
            primary_high_n_o     <= `CSH_OUT_IDLE;
            primary_low_n_o      <= `CSH_OUT_IDLE;
            secondary_reject_n_o <= `CSH_OUT_IDLE;
        end else if (meas_start_o) begin
            bin_select_n_o       <= bin_select_n_o;
        end else if (done_event && list_mode) begin
            bin_select_n_o       <= ~fail_next[8:0];
            out_of_bin_n_o       <= ~fail_next[9];
            aux_n_o              <= ~(|fail_next);
            primary_high_n_o     <= 1'b1;
            primary_low_n_o      <= 1'b1;
            secondary_reject_n_o <= 1'b1;
        end else if (done_event) begin
            // one bin line for good, out of bin for over, aux for not good
            bin_select_n_o <= ~(((bin_class_i == `CSH_CLASS_GOOD) &&
                                 (bin_number_i != 4'h0) && (bin_number_i <= 4'h9))
                                ? (9'h001 << (bin_number_i - 4'h1)) : 9'h000);
            out_of_bin_n_o       <= ~(bin_class_i == `CSH_CLASS_OVER);
            aux_n_o              <= ~(aux_bin_i | (bin_class_i == `CSH_CLASS_NG));
            primary_high_n_o     <= ~prim_above_i;
            primary_low_n_o      <= ~prim_below_i;
            secondary_reject_n_o <= ~sec_outside_i;
        end
    end
    // results and end of measurement share one edge, so the handler never
    // sees end of measurement before the result lines have settled
    // a part class outside the three known codes lights no bin line and
    // leaves the out-of-bin line released
    // limitation: the point count is taken as it stands at each step, so it
    // must not change while a sweep is running

endmodule

`default_nettype wire

// ===== csh_port_monitor.sv
// checker for the handler port block
`timescale 1ns/10ps
`default_nettype none
module csh_port_monitor (
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        ext_trigger_in_mode_i,
    input wire logic        panel_lock_n_i,
    input wire logic [15:0] panel_keys_o,
    input wire logic        circuit_break_i,
    input wire logic        compare_mode_i,
    input wire logic        analog_step_i,
    input wire logic        compare_step_i,
    input wire logic        meas_start_o,
    input wire logic [8:0]  bin_select_n_o,
    input wire logic        analog_done_n_o,
    input wire logic        measure_done_n_o,
    input wire logic        fault_alert_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    start_clears_a:
        assert property (meas_start_o |=> analog_done_n_o && measure_done_n_o)
        else $error("done outputs kept after start");
    analog_done_a:
        assert property (!compare_mode_i && analog_step_i && !meas_start_o |=> !analog_done_n_o)
        else $error("analog done missing");
    meas_done_a:
        assert property (!compare_mode_i && compare_step_i && !meas_start_o |=> !measure_done_n_o)
        else $error("end of measurement missing");
    done_holds_a:
        assert property (!measure_done_n_o && !meas_start_o |=> !measure_done_n_o)
        else $error("end of measurement dropped early");
    bins_held_a:
        assert property (!measure_done_n_o && !compare_step_i |=> $stable(bin_select_n_o))
        else $error("bin lines moved while done");
    alarm_set_a:
        assert property (circuit_break_i [*4] |-> !fault_alert_n_o)
        else $error("fault alert missing");
    keys_locked_a:
        assert property (!panel_lock_n_i [*4] |-> panel_keys_o == 16'h0000)
        else $error("keys pass while locked");
    no_trig_mode_a:
        assert property (!ext_trigger_in_mode_i |-> !meas_start_o)
        else $error("start outside trigger mode");
endmodule
bind csh_handler_port csh_port_monitor u_mon (.clock_i(clock_i), .nrst_i(nrst_i),
    .ext_trigger_in_mode_i(ext_trigger_in_mode_i), .panel_lock_n_i(panel_lock_n_i),
    .panel_keys_o(panel_keys_o), .circuit_break_i(circuit_break_i),
    .compare_mode_i(compare_mode_i), .analog_step_i(analog_step_i),
    .compare_step_i(compare_step_i), .meas_start_o(meas_start_o),
    .bin_select_n_o(bin_select_n_o), .analog_done_n_o(analog_done_n_o),
    .measure_done_n_o(measure_done_n_o), .fault_alert_n_o(fault_alert_n_o));
`default_nettype wire

// ===== csh_handler_model.sv
// handler model: trigger pulses and result capture
`timescale 1ns/10ps
`default_nettype none
module csh_handler_model (
    input  wire logic        clock_i,
    input  wire logic        measure_done_n_i,
    input  wire logic [10:0] result_i,
    output var  logic        ext_trigger_in_o,
    output var  logic [10:0] seen_o
);
    logic last_q = 1'b1;
    initial ext_trigger_in_o = 1'b0;
    // hold the trigger high for w whole cycles
    task pulse(input int w);
        @(negedge clock_i);
        ext_trigger_in_o = 1'b1;
        repeat (w) @(negedge clock_i);
        ext_trigger_in_o = 1'b0;
    endtask
    // take results only once end of measurement is low
    always @(negedge clock_i) begin
        if (!measure_done_n_i && last_q) seen_o <= result_i;
        last_q <= measure_done_n_i;
    end
endmodule
`default_nettype wire

// ===== csh_handler_port_bench.sv
// self-checking bench for the handler port block
`timescale 1ns/10ps
`default_nettype none
module csh_handler_port_bench;
    logic        clock_i = 0, nrst_i = 0, tm = 1, lock_n = 1, brk = 0, cm = 0, sq = 0;
    logic        as_ = 0, cs = 0, pf = 0, ax = 0, pa = 0, pb = 0, so = 0, trg, st, got;
    logic        oob, aux, hi_n, lo_n, srj, adn, mdn, fan;
    logic [15:0] keys = 0, keo;
    logic [3:0]  np = 1, pi = 0, bn = 1;
    logic [1:0]  cl = 0;
    logic [8:0]  bsel;
    logic [10:0] seen, e;
    logic [13:0] eb;
    logic [31:0] seed = 32'h30BF2CE8, r;
    int          checked = 0, mismatches = 0, cyc = 0, i, p;
    csh_handler_port dut (.clock_i(clock_i), .nrst_i(nrst_i), .ext_trigger_in_mode_i(tm),
        .ext_trigger_in_i(trg), .panel_lock_n_i(lock_n), .panel_keys_i(keys), .panel_keys_o(keo),
        .circuit_break_i(brk), .compare_mode_i(cm), .sequential_sweep_i(sq), .sweep_points_i(np),
        .analog_step_i(as_), .compare_step_i(cs), .point_index_i(pi), .point_fail_i(pf),
        .bin_class_i(cl), .bin_number_i(bn), .aux_bin_i(ax), .prim_above_i(pa),
        .prim_below_i(pb), .sec_outside_i(so), .meas_start_o(st), .bin_select_n_o(bsel),
        .out_of_bin_n_o(oob), .aux_n_o(aux), .primary_high_n_o(hi_n), .primary_low_n_o(lo_n),
        .secondary_reject_n_o(srj), .analog_done_n_o(adn), .measure_done_n_o(mdn),
        .fault_alert_n_o(fan));
    csh_handler_model u_hdl (.clock_i(clock_i), .measure_done_n_i(mdn),
        .result_i({aux, oob, bsel}), .ext_trigger_in_o(trg), .seen_o(seen));
    always #50 clock_i = ~clock_i;
    // xorshift source with a fixed start
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected bin mode outputs, active low
    function logic [13:0] bexp(input logic [1:0] c, input logic [3:0] b, input logic x, h, l, s);
        bexp = {~s, ~l, ~h, 11'h7FF};
        if (c == 2'h0) bexp[b - 1] = 1'b0;
        if (c == 2'h1) bexp[9] = 1'b0;
        if (c == 2'h2 || x) bexp[10] = 1'b0;
    endfunction
    task chk(input string nm, input logic [31:0] g, x);
        checked++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one cycle step pulse, then a gap cycle
    task step(input logic c);
        if (c) cs = 1; else as_ = 1;
        @(negedge clock_i);
        cs = 0;
        as_ = 0;
        @(negedge clock_i);
    endtask
    // trigger pulse of w cycles, watching for a start
    task trig(input int w, input logic x);
        got = 0;
        fork
            u_hdl.pulse(w);
            repeat (w + 6) @(negedge clock_i) if (st === 1'b1) got = 1;
        join
        chk("start", got, x);
    endtask
    always @(posedge clock_i) if (++cyc == 6000) begin
        mismatches++;
        end_of_test;
    end
    initial begin
        repeat (5) @(negedge clock_i);
        nrst_i = 1;
        repeat (3) @(negedge clock_i);
        chk("idle", {srj, lo_n, hi_n, aux, oob, bsel, adn, mdn, fan}, 17'h1FFFF);
        trig(9, 0);
        tm = 0;
        trig(12, 0);
        tm = 1;
        $display("test trigger done");
        for (i = 0; i < 12; i++) begin
            r = rnd();
            {ax, pa, pb, so} = r[7:4];
            cl = i % 3;
            bn = r[3:0] % 9 + 1;
            eb = bexp(cl, bn, ax, pa, pb, so);
            trig(10, 1);
            chk("done_clear", {adn, mdn}, 2'b11);
            step(0);
            chk("analog", {adn, mdn}, 2'b01);
            step(1);
            chk("meas_done", mdn, 0);
            chk("bin", {srj, lo_n, hi_n, aux, oob, bsel}, eb);
            chk("taken", seen, eb[10:0]);
        end
        $display("test bin done");
        cm = 1;
        for (i = 0; i < 4; i++) begin
            r = rnd();
            sq = i[0];
            np = (i == 3) ? 10 : r[3:0] % 10 + 1;
            e = 11'h7FF;
            trig(10, 1);
            for (p = 0; p < np; p++) begin
                step(0);
                chk("index", adn, sq && p < np - 1);
                pi = p;
                pf = r[p + 4];
                if (pf) e[p] = 0;
                if (pf) e[10] = 0;
                step(1);
                chk("point_done", mdn, sq && p < np - 1);
            end
            chk("list", {aux, oob, bsel}, e);
        end
        $display("test list done");
        keys = rnd();
        lock_n = 0;
        repeat (3) @(negedge clock_i);
        chk("keys_locked", keo, 0);
        lock_n = 1;
        brk = 1;
        repeat (5) @(negedge clock_i);
        chk("keys_free", keo, keys);
        chk("alarm", fan, 0);
        $display("test lock and alarm done");
        end_of_test;
    end
endmodule
`default_nettype wire
